// File: core/pife_debounce.sv
/*
  One debounce channel: the raw pin is registered twice, then the state
  only follows after the level has stood still for the full interval.
  Assumes pins asynchronous to mclk; a tick-free counter in mclk cycles.
*/
`timescale 1ns/1ps
`include "pife_defs.svh"

module pife_debounce #(
  parameter int CNT_W = 26
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control
  input wire logic enable,
  input wire logic [CNT_W-1:0] limit,
  // Pin and result
  input wire logic pin_n,
  output logic state
);

  logic sync1_r;
  logic sync2_r;
  logic [CNT_W-1:0] count_r;
  logic state_r;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end
    else
    begin
      sync1_r <= pin_n;
      sync2_r <= sync1_r;
    end
  end

  // Pressed is low on the pin; any bounce restarts the count
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_r <= '0;
      state_r <= 1'b0;
    end
    else if (!enable || (~sync2_r == state_r))
    begin
      count_r <= '0;
    end
    else if (count_r >= limit - CNT_W'(1))
    begin
      count_r <= '0;
      state_r <= ~sync2_r;
    end
    else
    begin
      count_r <= count_r + CNT_W'(1);
    end
  end

  assign state = state_r;

endmodule : pife_debounce

// File: core/pife_defs.svh
/*
  Constants of the pointer input front end: configuration byte fields,
  motion modes and debounce timing.
  Assumes inclusion by bare name from the core files.
*/
`ifndef PIFE_DEFS_SVH
`define PIFE_DEFS_SVH

// Clock period in picoseconds (125 MHz)
`define PIFE_CLK_PS 8000
// Debounce base step in milliseconds; interval is (sel+1) steps
`define PIFE_DEB_STEP_MS 15
// Cycles in one 15 ms step, derived from the clock rate
`define PIFE_DEB_STEP_CYC \
  ((`PIFE_DEB_STEP_MS * 64'd1000000000) / `PIFE_CLK_PS)
// Configuration byte 3 holds debounce_sel in bits 3:2
`define PIFE_DEB_BYTE 3
`define PIFE_DEB_LSB 2
`define PIFE_DEB_MSB 3
// Configuration byte 0 holds roller pair count in bits 1:0
`define PIFE_ROLL_BYTE 0
// Configuration byte 3 holds function select in bits 1:0
`define PIFE_FUNC_BYTE 3
`define PIFE_FUNC_JOY 2'h2
// Number of configuration bytes loaded
`define PIFE_CFG_BYTES 5
// Button and motion input counts
`define PIFE_NUM_BTN 8
`define PIFE_NUM_MOT 6

`endif

// File: core/pife_front_end.sv
/*
  Pointer input front end: conditions eight buttons and six motion
  inputs, decodes their use from the configuration bytes, and passes
  the four memory port pins through while the programming mode is on.
  Assumes configuration bytes come from the memory loader with a
  cfg_valid strobe after each chip or bus reset.
*/
// How it works
// - Roller mode pairs horiz_a/b, aux_a/b and vert_a/b as two-wire pairs.
// - Joystick mode uses only the horiz pair, fed by a potentiometer.
// - Button mode senses every motion input alone, active low.
// - Motion inputs are pulled up; those acting as buttons are debounced per configuration bytes.
// - Button inputs, including the button/LED pin, are pulled up, low pressed.
// - Button inputs are debounced with the configured interval.
// - debounce_sel in byte 3 bits 3:2 picks 15, 30, 45 or 60 ms.
// - Three button pins double as the memory serial port.
// - Configuration loads at power-on and bus reset before running.
`timescale 1ns/1ps
`include "pife_defs.svh"

module pife_front_end #(
  parameter int CNT_W = 26,
  parameter longint DEB_STEP_CYC = `PIFE_DEB_STEP_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Configuration load
  input wire logic bus_reset,
  input wire logic cfg_valid,
  input wire logic [8*`PIFE_CFG_BYTES-1:0] config_bytes,
  input wire logic prog_mode,
  // Button pins, bit 0 mem_select, 1 mem_clock, 2 mem_data_in,
  // 7 button_led_pin
  input wire logic [`PIFE_NUM_BTN-1:0] button_n,
  // Motion pins
  input wire logic horiz_a,
  input wire logic horiz_b,
  input wire logic aux_a,
  input wire logic aux_b,
  input wire logic vert_a,
  input wire logic vert_b,
  // Memory port
  input wire logic mem_rd_data,
  output logic mem_select,
  output logic mem_clock,
  output logic mem_data_in,
  output logic mem_data_out,
  output logic mem_data_out_oe_n,
  // Pull-up enables, high when active
  output logic [`PIFE_NUM_BTN+`PIFE_NUM_MOT-1:0] pullup_en,
  // Report side
  output logic running,
  output logic [`PIFE_NUM_BTN-1:0] button_state,
  output logic [`PIFE_NUM_MOT-1:0] motion_button,
  output logic [`PIFE_NUM_MOT-1:0] roller_level,
  output logic [2:0] roller_pair_en,
  output logic joystick_en,
  output logic joy_a,
  output logic joy_b
);

  pife_pkg::pife_state_type state_r;
  logic [1:0] deb_sel_r;
  logic [1:0] roll_r;
  logic [1:0] func_r;
  logic [CNT_W-1:0] limit;
  logic [`PIFE_NUM_MOT-1:0] mot_n;
  logic [`PIFE_NUM_MOT-1:0] mot_is_btn;
  logic [`PIFE_NUM_MOT-1:0] mot_r;
  logic [`PIFE_NUM_BTN-1:0] btn_en;
  pife_pkg::pife_mot_type mode;

  // Pair order in the vector: horiz, vert, aux
  assign mot_n = {aux_b, aux_a, vert_b, vert_a, horiz_b, horiz_a};

  // Settings only change after a full load, never mid-run
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= pife_pkg::PIFE_ST_LOAD;
      deb_sel_r <= 2'h0;
      roll_r <= 2'h0;
      func_r <= 2'h0;
    end
    else
    begin
      case (state_r)
        pife_pkg::PIFE_ST_LOAD:
        begin
          if (cfg_valid)
          begin
            deb_sel_r <= config_bytes[8*`PIFE_DEB_BYTE+`PIFE_DEB_LSB +: 2];
            roll_r <= config_bytes[8*`PIFE_ROLL_BYTE +: 2];
            func_r <= config_bytes[8*`PIFE_FUNC_BYTE +: 2];
            state_r <= pife_pkg::PIFE_ST_RUN;
          end
        end
        pife_pkg::PIFE_ST_RUN:
        begin
          if (bus_reset)
          begin
            state_r <= pife_pkg::PIFE_ST_LOAD;
          end
        end
        default:
        begin
          state_r <= pife_pkg::PIFE_ST_LOAD;
        end
      endcase
    end
  end

  assign running = (state_r == pife_pkg::PIFE_ST_RUN);

  // Interval is (sel+1) times 15 ms
  assign limit = CNT_W'(DEB_STEP_CYC * (deb_sel_r + 1));

  assign mode = (func_r == `PIFE_FUNC_JOY) ? pife_pkg::PIFE_MOT_JOYSTICK :
                (roll_r != 2'h0) ? pife_pkg::PIFE_MOT_ROLLER :
                pife_pkg::PIFE_MOT_BUTTON;

  // Pairs enabled in order horiz, vert, aux as the roller count rises
  always_comb
  begin
    roller_pair_en = 3'h0;
    joystick_en = 1'b0;
    case (mode)
      pife_pkg::PIFE_MOT_ROLLER:
      begin
        roller_pair_en[0] = 1'b1;
        roller_pair_en[1] = roll_r[1];
        roller_pair_en[2] = (roll_r == 2'h3);
      end
      pife_pkg::PIFE_MOT_JOYSTICK:
      begin
        joystick_en = 1'b1;
      end
      default:
      begin
        roller_pair_en = 3'h0;
      end
    endcase
  end

  // Inputs outside an active pair act as separate buttons
  assign mot_is_btn = ~{{2{roller_pair_en[2]}}, {2{roller_pair_en[1]}},
    {2{roller_pair_en[0] | joystick_en}}};

  // Memory port pins are not buttons during programming
  assign btn_en = prog_mode ? 8'h78 | 8'h80 : 8'hFF;

  genvar gi;
  generate
    for (gi = 0; gi < `PIFE_NUM_BTN; gi = gi + 1)
    begin : g_btn
      pife_debounce #(.CNT_W(CNT_W)) u_deb (
        .mclk(mclk),
        .arst_n(arst_n),
        .enable(running & btn_en[gi]),
        .limit(limit),
        .pin_n(button_n[gi]),
        .state(button_state[gi])
      );
    end
    for (gi = 0; gi < `PIFE_NUM_MOT; gi = gi + 1)
    begin : g_mot
      pife_debounce #(.CNT_W(CNT_W)) u_deb (
        .mclk(mclk),
        .arst_n(arst_n),
        .enable(running & mot_is_btn[gi]),
        .limit(limit),
        .pin_n(mot_n[gi]),
        .state(motion_button[gi])
      );
    end
  endgenerate

  assign pullup_en = '1;

  // Roller levels registered without debounce, which would eat edges
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mot_r <= '1;
    end
    else
    begin
      mot_r <= mot_n;
    end
  end

  assign roller_level = mot_r;
  assign joy_a = mot_r[0];
  assign joy_b = mot_r[1];

  // Serial port pass-through
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_select <= 1'b0;
      mem_clock <= 1'b0;
      mem_data_in <= 1'b0;
      mem_data_out <= 1'b1;
    end
    else
    begin
      mem_select <= prog_mode & button_n[0];
      mem_clock <= prog_mode & button_n[1];
      mem_data_in <= prog_mode & button_n[2];
      mem_data_out <= mem_rd_data;
    end
  end

  assign mem_data_out_oe_n = ~(prog_mode & mem_select);

endmodule : pife_front_end

// File: core/pife_pkg.sv
/*
  Types of the pointer input front end.
  Assumes pife_defs.svh is compiled alongside.
*/
package pife_pkg;

  typedef enum logic [1:0]
  {
    PIFE_ST_LOAD,
    PIFE_ST_RUN
  } pife_state_type;

  typedef enum logic [1:0]
  {
    PIFE_MOT_BUTTON,
    PIFE_MOT_ROLLER,
    PIFE_MOT_JOYSTICK
  } pife_mot_type;

endpackage : pife_pkg

// File: dv/pife_fe_sva.sv
/* Port checker for the pointer input front end.
   Assumes a bind onto pife_front_end and a sim step of 4 cycles. */
`timescale 1ns/1ps
`include "pife_defs.svh"
module pife_fe_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Inputs
  input wire logic cfg_valid,
  input wire logic bus_reset,
  input wire logic [8*`PIFE_CFG_BYTES-1:0] config_bytes,
  input wire logic prog_mode,
  input wire logic [`PIFE_NUM_BTN-1:0] button_n,
  input wire logic mem_rd_data,
  // Outputs
  input wire logic mem_select,
  input wire logic mem_data_out,
  input wire logic [`PIFE_NUM_BTN+`PIFE_NUM_MOT-1:0] pullup_en,
  input wire logic running,
  input wire logic [`PIFE_NUM_BTN-1:0] button_state,
  input wire logic [2:0] roller_pair_en,
  input wire logic joystick_en
);
  logic [3:0] cfg_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Mirror of function and roller fields taken at load
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cfg_r <= 4'h0;
    else if (cfg_valid && !running)
      cfg_r <= {config_bytes[25:24], config_bytes[1:0]};
  end
  sequence hi_s;
    button_n[3] [*3];
  endsequence
  sequence lo_s;
    !button_n[3] [*3];
  endsequence
  run_start_a: assert property (!running && cfg_valid |=> running)
    else $error("running not raised");
  run_stop_a: assert property (running && bus_reset |=> !running)
    else $error("running not dropped");
  pullup_on_a: assert property (&pullup_en)
    else $error("pull-up off");
  press_wait_a: assert property (
    hi_s ##1 (!button_n[3] && !button_state[3]) |=> !button_state[3] [*3])
    else $error("press taken early");
  release_wait_a: assert property (
    lo_s ##1 (button_n[3] && button_state[3]) |=> button_state[3] [*3])
    else $error("release taken early");
  // The last sample that completes a count is three cycles before the rise
  press_cause_a: assert property ($rose(button_state[3]) |->
    !$past(button_n[3], 3) && !$past(button_n[3], 4))
    else $error("press without low pin");
  // Joystick use takes every pair away from roller duty
  roll_pair_a: assert property (running |-> roller_pair_en ==
    ((cfg_r[3:2] == 2'h2) ? 3'h0 : {&cfg_r[1:0], cfg_r[1], |cfg_r[1:0]}))
    else $error("roller pairs wrong");
  joy_sel_a: assert property (running |->
    joystick_en == (cfg_r[3:2] == 2'h2))
    else $error("joystick select wrong");
  mem_pass_a: assert property (prog_mode |=>
    mem_select == $past(button_n[0]) && mem_data_out == $past(mem_rd_data))
    else $error("memory port not passed");
endmodule : pife_fe_sva

// File: dv/pife_pin_model.sv
/* Switches and photo-diode pins on the far side.
   Assumes press requests from the bench; idle contacts float high. */
`timescale 1ns/1ps
module pife_pin_model (
  // Press requests
  input wire logic [7:0] press_btn,
  input wire logic [5:0] press_mot,
  // Pins
  output logic [7:0] button_n,
  output logic horiz_a,
  output logic horiz_b,
  output logic aux_a,
  output logic aux_b,
  output logic vert_a,
  output logic vert_b
);
  // Open contact is pulled up, closed one pulls low
  assign button_n = ~press_btn;
  assign {aux_b, aux_a, vert_b, vert_a, horiz_b, horiz_a} = ~press_mot;
endmodule : pife_pin_model

// File: dv/tb_pointer_input_front_end.sv
/* Self-checking bench of the pointer input front end.
   Assumes the design with a step of 4 cycles per debounce unit. */
`timescale 1ns/1ps
module tb_pointer_input_front_end;
  logic mclk = 0, arst_n = 0, bus_reset = 0, cfg_valid = 0;
  logic prog_mode = 0, mem_rd_data = 0;
  logic [39:0] config_bytes = '0;
  logic [7:0] press_btn = '0, button_n, button_state;
  logic [5:0] press_mot = '0, motion_button, roller_level;
  logic horiz_a, horiz_b, aux_a, aux_b, vert_a, vert_b, joystick_en;
  logic joy_a, joy_b;
  logic mem_select, mem_clock, mem_data_in, mem_data_out, mem_oe_n, running;
  logic [13:0] pullup_en;
  logic [2:0] roller_pair_en;
  int err_total = 0, cmp_count = 0, n, k, b;
  integer seed = 87;
  pife_pin_model i_pins (.press_btn(press_btn), .press_mot(press_mot),
    .button_n(button_n), .horiz_a(horiz_a), .horiz_b(horiz_b),
    .aux_a(aux_a), .aux_b(aux_b), .vert_a(vert_a), .vert_b(vert_b));
  pife_front_end #(.CNT_W(26), .DEB_STEP_CYC(4)) i_dut (.mclk(mclk),
    .arst_n(arst_n), .bus_reset(bus_reset), .cfg_valid(cfg_valid),
    .config_bytes(config_bytes), .prog_mode(prog_mode),
    .button_n(button_n), .horiz_a(horiz_a), .horiz_b(horiz_b),
    .aux_a(aux_a), .aux_b(aux_b), .vert_a(vert_a), .vert_b(vert_b),
    .mem_rd_data(mem_rd_data), .mem_select(mem_select),
    .mem_clock(mem_clock), .mem_data_in(mem_data_in),
    .mem_data_out(mem_data_out), .mem_data_out_oe_n(mem_oe_n),
    .pullup_en(pullup_en), .running(running), .button_state(button_state),
    .motion_button(motion_button), .roller_level(roller_level),
    .roller_pair_en(roller_pair_en), .joystick_en(joystick_en),
    .joy_a(joy_a), .joy_b(joy_b));
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  task tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : tick
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Joystick use leaves no roller pair active
  function automatic logic [2:0] pairs(input logic [1:0] r,
    input logic [1:0] f);
    return (f == 2'h2) ? 3'h0 : {r == 2'h3, r[1], r != 2'h0};
  endfunction : pairs
  task load(input logic [1:0] r, input logic [1:0] f, input logic [1:0] d);
    bus_reset = 1;
    tick(1);
    bus_reset = 0;
    config_bytes = {12'h000, d, f, 22'h00_0000, r};
    cfg_valid = 1;
    tick(1);
    cfg_valid = 0;
    tick(1);
    chk(running, 1);
  endtask : load
  task end_of_test;
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    tick(5);
    arst_n = 1;
    chk(running, 0);
    chk(roller_level, 8'h3f);
    chk(pullup_en[13:8], 8'h3f);
    for (int d = 0; d < 4; d++)
    begin
      n = (d + 1) * 4;
      b = 7 - 2 * d;
      load(0, 0, d[1:0]);
      press_btn[b] = 1;
      tick(1 + $unsigned($random(seed)) % (n - 2));
      press_btn[b] = 0;
      tick(n + 4);
      chk(button_state[b], 0);
      press_btn[b] = 1;
      tick(n);
      chk(button_state[b], 0);
      k = 0;
      while (button_state[b] !== 1'b1 && k < 8)
      begin
        tick(1);
        k++;
      end
      chk(button_state[b], 1);
      chk(k, 2);
      press_btn[b] = 0;
      tick(n + 6);
      chk(button_state[b], 0);
    end
    press_mot = 6'h01;
    // Last load left the 60 ms setting: 16 cycles plus two sync stages
    tick(20);
    chk(motion_button, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      load(i[1:0], i[1:0], 0);
      chk(roller_pair_en, pairs(i[1:0], i[1:0]));
      chk(joystick_en, i == 2);
      press_mot = 6'($random(seed));
      tick(4);
      chk(roller_level, 6'(~press_mot));
      chk({joy_b, joy_a}, 2'(~press_mot[1:0]));
    end
    press_mot = 0;
    prog_mode = 1;
    repeat (6)
    begin
      press_btn = 8'($random(seed));
      mem_rd_data = 1'($random(seed));
      tick(2);
      chk({mem_data_in, mem_clock, mem_select}, 3'(~press_btn[2:0]));
      chk(mem_oe_n, press_btn[0]);
      chk(mem_data_out, mem_rd_data);
      // Select pin low 32 cycles between opcodes
      press_btn = 8'h01;
      tick(32);
    end
    end_of_test();
  end
  initial
  begin
    tick(5000);
    err_total++;
    end_of_test();
  end
endmodule : tb_pointer_input_front_end
bind pife_front_end pife_fe_sva i_sva (.mclk(mclk), .arst_n(arst_n),
  .cfg_valid(cfg_valid), .bus_reset(bus_reset), .config_bytes(config_bytes),
  .prog_mode(prog_mode), .button_n(button_n), .mem_rd_data(mem_rd_data),
  .mem_select(mem_select), .mem_data_out(mem_data_out),
  .pullup_en(pullup_en), .running(running), .button_state(button_state),
  .roller_pair_en(roller_pair_en), .joystick_en(joystick_en));
